//--- hw/abeu_core.sv
// apb-controlled execute unit for alu, compare, skip and branch operations
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

module abeu_core #(
  parameter int PC_W = 9,
  parameter int STACK_DEPTH = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // execution state
  output logic busy
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  logic [31:0] instr_q;
  logic [7:0] opd_q;
  logic [7:0] opr_q;
  logic [7:0] io_q;
  logic [7:0] status_flag_register_q;
  logic [7:0] result_q;
  logic [PC_W-1:0] pc_q;
  logic [2:0] cnt_q;
  logic [2:0] last_cyc_q;
  logic taken_q;
  logic illegal_q;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [SP_W-1:0] sp_q;

  abeu_pkg::abeu_op_t op;
  logic [abeu_pkg::BIT_W-1:0] bsel;
  logic [7:0] kimm;
  logic signed [abeu_pkg::OFF_W-1:0] k_off;
  logic [PC_W-1:0] pc_next1;
  logic [PC_W-1:0] pc_skip;
  logic [PC_W-1:0] pc_rel;

  abeu_pkg::abeu_alu_t alu;
  logic [7:0] res_d;
  logic wr_d;
  logic [7:0] status_flag_register_d;
  logic [PC_W-1:0] pc_d;
  logic push_d;
  logic pop_d;
  logic [2:0] cyc_d;
  logic taken_d;
  logic illegal_d;
  logic commit;

  logic apb_wait;
  logic apb_done;
  logic wr_fire;
  logic [31:0] rdata;
  logic rd_err;
  logic wr_err;

  //////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  function automatic abeu_pkg::abeu_alu_t add_f(input logic [7:0] a, input logic [7:0] b,
                                                input logic cin);
    abeu_pkg::abeu_alu_t f;
    logic a3, b3, r3, a7, b7, r7;
    f.r = 8'(a + b + 8'(cin));
    a3 = a[abeu_pkg::BIT_HALF];
    b3 = b[abeu_pkg::BIT_HALF];
    r3 = f.r[abeu_pkg::BIT_HALF];
    a7 = a[abeu_pkg::BIT_SIGN];
    b7 = b[abeu_pkg::BIT_SIGN];
    r7 = f.r[abeu_pkg::BIT_SIGN];
    f.h = (a3 & b3) | (b3 & ~r3) | (~r3 & a3);
    f.v = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
    f.c = (a7 & b7) | (b7 & ~r7) | (~r7 & a7);
    return f;
  endfunction

  function automatic abeu_pkg::abeu_alu_t sub_f(input logic [7:0] a, input logic [7:0] b,
                                                input logic cin);
    abeu_pkg::abeu_alu_t f;
    logic a3, b3, r3, a7, b7, r7;
    f.r = 8'(a - b - 8'(cin));
    a3 = a[abeu_pkg::BIT_HALF];
    b3 = b[abeu_pkg::BIT_HALF];
    r3 = f.r[abeu_pkg::BIT_HALF];
    a7 = a[abeu_pkg::BIT_SIGN];
    b7 = b[abeu_pkg::BIT_SIGN];
    r7 = f.r[abeu_pkg::BIT_SIGN];
    f.h = (~a3 & b3) | (b3 & r3) | (r3 & ~a3);
    f.v = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
    f.c = (~a7 & b7) | (b7 & r7) | (r7 & ~a7);
    return f;
  endfunction

  // sign flag always follows n xor v so signed branches see a coherent state
  function automatic logic [7:0] arith_f(input logic [7:0] s, input abeu_pkg::abeu_alu_t f);
    logic [7:0] n;
    n = s;
    n[abeu_pkg::STATUS_FLAG_REGISTER_H] = f.h;
    n[abeu_pkg::STATUS_FLAG_REGISTER_V] = f.v;
    n[abeu_pkg::STATUS_FLAG_REGISTER_C] = f.c;
    n[abeu_pkg::STATUS_FLAG_REGISTER_N] = f.r[abeu_pkg::BIT_SIGN];
    n[abeu_pkg::STATUS_FLAG_REGISTER_Z] = ~|f.r;
    n[abeu_pkg::STATUS_FLAG_REGISTER_S] = n[abeu_pkg::STATUS_FLAG_REGISTER_N] ^ n[abeu_pkg::STATUS_FLAG_REGISTER_V];
    return n;
  endfunction

  function automatic logic [7:0] logic_f(input logic [7:0] s, input logic [7:0] r);
    logic [7:0] n;
    n = s;
    n[abeu_pkg::STATUS_FLAG_REGISTER_V] = 1'b0;
    n[abeu_pkg::STATUS_FLAG_REGISTER_N] = r[abeu_pkg::BIT_SIGN];
    n[abeu_pkg::STATUS_FLAG_REGISTER_Z] = ~|r;
    n[abeu_pkg::STATUS_FLAG_REGISTER_S] = n[abeu_pkg::STATUS_FLAG_REGISTER_N] ^ n[abeu_pkg::STATUS_FLAG_REGISTER_V];
    return n;
  endfunction

  function automatic logic is_skip_f(input abeu_pkg::abeu_op_t o);
    return o inside {abeu_pkg::compare_skip_equal_op, abeu_pkg::skip_reg_bit_clear_op,
                     abeu_pkg::skip_reg_bit_set_op, abeu_pkg::skip_io_bit_clear_op,
                     abeu_pkg::skip_io_bit_set_op};
  endfunction

  function automatic logic is_branch_f(input abeu_pkg::abeu_op_t o);
    return o inside {[abeu_pkg::branch_flag_set_op:abeu_pkg::relative_call_op]};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // decode and execute

  assign op = abeu_pkg::abeu_op_t'(instr_q[abeu_pkg::FLD_OP_LSB +: abeu_pkg::OP_W]);
  assign bsel = instr_q[abeu_pkg::FLD_BIT_LSB +: abeu_pkg::BIT_W];
  assign kimm = instr_q[abeu_pkg::FLD_K_LSB +: abeu_pkg::K_W];
  assign k_off = instr_q[abeu_pkg::FLD_OFF_LSB +: abeu_pkg::OFF_W];
  assign pc_next1 = PC_W'(pc_q + PC_W'(abeu_pkg::PC_STEP_NEXT));
  assign pc_skip = PC_W'(pc_q + PC_W'(abeu_pkg::PC_STEP_SKIP));
  assign pc_rel = PC_W'(pc_q + PC_W'(k_off) + PC_W'(abeu_pkg::PC_STEP_NEXT));

  always_comb begin
    alu = '0;
    res_d = opd_q;
    wr_d = 1'b0;
    status_flag_register_d = status_flag_register_q;
    pc_d = pc_next1;
    push_d = 1'b0;
    pop_d = 1'b0;
    cyc_d = abeu_pkg::CYC_ONE;
    taken_d = 1'b0;
    illegal_d = 1'b0;
    unique case (op)
      abeu_pkg::nop_op: begin
      end
      abeu_pkg::add_carry_op: begin
        alu = add_f(opd_q, opr_q, status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_C]);
      end
      abeu_pkg::subtract_immediate_op: begin
        alu = sub_f(opd_q, kimm, 1'b0);
      end
      abeu_pkg::subtract_borrow_reg_op: begin
        alu = sub_f(opd_q, opr_q, status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_C]);
      end
      abeu_pkg::subtract_borrow_imm_op: begin
        alu = sub_f(opd_q, kimm, status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_C]);
      end
      abeu_pkg::compare_immediate_op: begin
        alu = sub_f(opd_q, kimm, 1'b0);
      end
      abeu_pkg::and_immediate_op: begin
        res_d = opd_q & kimm;
      end
      abeu_pkg::or_immediate_op: begin
        res_d = opd_q | kimm;
      end
      abeu_pkg::clear_bits_op: begin
        res_d = opd_q & (abeu_pkg::MASK_ALL - kimm);
      end
      abeu_pkg::set_bits_op: begin
        res_d = opd_q | kimm;
      end
      abeu_pkg::test_zero_minus_op: begin
        res_d = opd_q & opd_q;
      end
      abeu_pkg::compare_skip_equal_op: taken_d = (opd_q == opr_q);
      abeu_pkg::skip_reg_bit_clear_op: taken_d = ~opr_q[bsel];
      abeu_pkg::skip_reg_bit_set_op: taken_d = opr_q[bsel];
      abeu_pkg::skip_io_bit_clear_op: taken_d = ~io_q[bsel];
      abeu_pkg::skip_io_bit_set_op: taken_d = io_q[bsel];
      abeu_pkg::branch_flag_set_op: taken_d = status_flag_register_q[bsel];
      abeu_pkg::branch_flag_clear_op: taken_d = ~status_flag_register_q[bsel];
      abeu_pkg::branch_signed_ge_op: begin
        taken_d = ~(status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_N] ^ status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_V]);
      end
      abeu_pkg::branch_signed_lt_op: begin
        taken_d = status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_N] ^ status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_V];
      end
      abeu_pkg::branch_unsigned_ge_op: taken_d = ~status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_C];
      abeu_pkg::branch_unsigned_below_op: taken_d = status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_C];
      abeu_pkg::branch_halfcarry_set_op: taken_d = status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_H];
      abeu_pkg::branch_halfcarry_clear_op: taken_d = ~status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_H];
      abeu_pkg::branch_irq_enabled_op: taken_d = status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_I];
      abeu_pkg::branch_irq_disabled_op: taken_d = ~status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_I];
      abeu_pkg::relative_jump_op: begin
        taken_d = 1'b1;
      end
      abeu_pkg::relative_call_op: begin
        taken_d = 1'b1;
        push_d = 1'b1;
      end
      abeu_pkg::subroutine_return_op, abeu_pkg::interrupt_return_op: begin
        pop_d = 1'b1;
        pc_d = stack_q[0];
        cyc_d = abeu_pkg::CYC_FOUR;
        if (op == abeu_pkg::interrupt_return_op) begin
          status_flag_register_d[abeu_pkg::STATUS_FLAG_REGISTER_I] = 1'b1;
        end
      end
      default: illegal_d = 1'b1;
    endcase
    if (op inside {[abeu_pkg::add_carry_op:abeu_pkg::subtract_borrow_imm_op],
                   abeu_pkg::compare_immediate_op}) begin
      res_d = alu.r;
      status_flag_register_d = arith_f(status_flag_register_q, alu);
      wr_d = (op != abeu_pkg::compare_immediate_op);
    end
    if (op inside {[abeu_pkg::and_immediate_op:abeu_pkg::test_zero_minus_op]}) begin
      status_flag_register_d = logic_f(status_flag_register_q, res_d);
      wr_d = 1'b1;
    end
    // a skip assumes the next instruction is a single word
    if (is_skip_f(op) && taken_d) begin
      pc_d = pc_skip;
      cyc_d = abeu_pkg::CYC_TWO;
    end
    if (is_branch_f(op) && taken_d) begin
      pc_d = pc_rel;
      cyc_d = (op == abeu_pkg::relative_call_op) ? abeu_pkg::CYC_THREE : abeu_pkg::CYC_TWO;
    end
  end

  assign commit = busy && (cnt_q == cyc_d - abeu_pkg::CYC_ONE);

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, write lands on the completing edge

  assign apb_wait = psel && penable && !pready;
  assign apb_done = psel && penable && pready;
  assign wr_fire = apb_done && pwrite && !pslverr;

  always_comb begin
    rdata = abeu_pkg::RST_WORD;
    rd_err = 1'b0;
    unique case (paddr)
      abeu_pkg::ADDR_INSTR: rdata = instr_q;
      abeu_pkg::ADDR_OPD: rdata = 32'(opd_q);
      abeu_pkg::ADDR_OPR: rdata = 32'(opr_q);
      abeu_pkg::ADDR_IO: rdata = 32'(io_q);
      abeu_pkg::ADDR_STATUS_FLAG_REGISTER: rdata = 32'(status_flag_register_q);
      abeu_pkg::ADDR_PC: rdata = 32'(pc_q);
      abeu_pkg::ADDR_EXEC: begin
        rdata[abeu_pkg::EXS_BUSY] = busy;
        rdata[abeu_pkg::EXS_TAKEN] = taken_q;
        rdata[abeu_pkg::EXS_ILLEGAL] = illegal_q;
        rdata[abeu_pkg::EXS_CYC_LSB +: 3] = last_cyc_q;
        rdata[abeu_pkg::EXS_SP_LSB +: SP_W] = sp_q;
      end
      abeu_pkg::ADDR_RESULT: rdata = 32'(result_q);
      default: rd_err = 1'b1;
    endcase
    // status words are read-only, and nothing is writable mid-execution
    wr_err = rd_err || busy || (paddr == abeu_pkg::ADDR_EXEC) ||
             (paddr == abeu_pkg::ADDR_RESULT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= abeu_pkg::RST_WORD;
    end else if (apb_wait) begin
      pready <= 1'b1;
      pslverr <= pwrite ? wr_err : rd_err;
      prdata <= pwrite ? abeu_pkg::RST_WORD : rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= abeu_pkg::RST_WORD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // execution sequencing

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt_q <= '0;
      last_cyc_q <= '0;
      taken_q <= 1'b0;
      illegal_q <= 1'b0;
    end else if (wr_fire && paddr == abeu_pkg::ADDR_INSTR) begin
      busy <= 1'b1;
      cnt_q <= '0;
    end else if (commit) begin
      busy <= 1'b0;
      last_cyc_q <= cyc_d;
      taken_q <= taken_d;
      illegal_q <= illegal_d;
    end else if (busy) begin
      cnt_q <= cnt_q + abeu_pkg::CYC_ONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // architectural state: software writes only while idle, so no overlap

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= abeu_pkg::RST_WORD;
      opd_q <= abeu_pkg::RST_BYTE;
      opr_q <= abeu_pkg::RST_BYTE;
      io_q <= abeu_pkg::RST_BYTE;
      status_flag_register_q <= abeu_pkg::RST_BYTE;
      result_q <= abeu_pkg::RST_BYTE;
      pc_q <= '0;
    end else if (wr_fire) begin
      unique case (paddr)
        abeu_pkg::ADDR_INSTR: instr_q <= pwdata;
        abeu_pkg::ADDR_OPD: opd_q <= pwdata[7:0];
        abeu_pkg::ADDR_OPR: opr_q <= pwdata[7:0];
        abeu_pkg::ADDR_IO: io_q <= pwdata[7:0];
        abeu_pkg::ADDR_STATUS_FLAG_REGISTER: status_flag_register_q <= pwdata[7:0];
        abeu_pkg::ADDR_PC: pc_q <= pwdata[PC_W-1:0];
        default: begin
        end
      endcase
    end else if (commit) begin
      if (wr_d) begin
        opd_q <= res_d;
      end
      status_flag_register_q <= status_flag_register_d;
      result_q <= res_d;
      pc_q <= pc_d;
    end
  end

  // overflow drops the oldest entry, underflow returns zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= '0;
      end
      sp_q <= '0;
    end else if (commit && push_d) begin
      for (int i = STACK_DEPTH - 1; i > 0; i--) begin
        stack_q[i] <= stack_q[i-1];
      end
      stack_q[0] <= pc_next1;
      if (sp_q != SP_W'(STACK_DEPTH)) begin
        sp_q <= sp_q + SP_W'(1);
      end
    end else if (commit && pop_d) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stack_q[i] <= stack_q[i+1];
      end
      stack_q[STACK_DEPTH-1] <= '0;
      if (sp_q != '0) begin
        sp_q <= sp_q - SP_W'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  property p_adc_sum;
    @(posedge pclk) disable iff (!presetn)
    commit && op == abeu_pkg::add_carry_op |=>
      opd_q == 8'($past(opd_q) + $past(opr_q) + 8'($past(status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_C])));
  endproperty
  a_adc_sum: assert property (p_adc_sum) else $error("add with carry sum wrong");

  property p_subtract_immediate_op_one;
    @(posedge pclk) disable iff (!presetn)
    busy && !$past(busy) && op == abeu_pkg::subtract_immediate_op |->
      commit ##1 (!busy && opd_q == 8'($past(opd_q) - $past(kimm)));
  endproperty
  a_subtract_immediate_op_one: assert property (p_subtract_immediate_op_one) else $error("subtract immediate wrong");

  property p_logic_keep;
    @(posedge pclk) disable iff (!presetn)
    commit && op inside {[abeu_pkg::and_immediate_op:abeu_pkg::test_zero_minus_op]} |=>
      status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_C] == $past(status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_C]) &&
      status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_H] == $past(status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_H]) &&
      !status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_V];
  endproperty
  a_logic_keep: assert property (p_logic_keep) else $error("logic op flags wrong");

  property p_cpi_nowrite;
    @(posedge pclk) disable iff (!presetn)
    commit && op == abeu_pkg::compare_immediate_op |=>
      $stable(opd_q) && status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_Z] == ($past(opd_q) == $past(kimm));
  endproperty
  a_cpi_nowrite: assert property (p_cpi_nowrite) else $error("compare wrote rd");

  property p_skip_pc;
    @(posedge pclk) disable iff (!presetn)
    commit && is_skip_f(op) |=>
      $stable(status_flag_register_q) && pc_q == PC_W'($past(pc_q) + PC_W'($past(taken_d) ? 2 : 1));
  endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("skip moved pc wrongly");

  property p_skip_two;
    @(posedge pclk) disable iff (!presetn)
    busy && !$past(busy) && is_skip_f(op) && taken_d |-> !commit ##1 commit;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("taken skip not two cycles");

  property p_branch_signed_ge_op;
    @(posedge pclk) disable iff (!presetn)
    commit && op == abeu_pkg::branch_signed_ge_op |->
      taken_d == !(status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_N] ^ status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_V]);
  endproperty
  a_branch_signed_ge_op: assert property (p_branch_signed_ge_op) else $error("signed ge decision wrong");

  property p_branch_pc;
    @(posedge pclk) disable iff (!presetn)
    commit && is_branch_f(op) && taken_d |=>
      pc_q == PC_W'($past(pc_q) + PC_W'($past(k_off)) + PC_W'(1));
  endproperty
  a_branch_pc: assert property (p_branch_pc) else $error("branch target wrong");

  property p_call_three;
    @(posedge pclk) disable iff (!presetn)
    busy && !$past(busy) && op == abeu_pkg::relative_call_op |->
      !commit[*2] ##1 commit ##1 stack_q[0] == PC_W'($past(pc_q, 2) + PC_W'(1));
  endproperty
  a_call_three: assert property (p_call_three) else $error("call timing or push wrong");

  property p_ret_four;
    @(posedge pclk) disable iff (!presetn)
    busy && !$past(busy) && op == abeu_pkg::interrupt_return_op |->
      !commit[*3] ##1 commit ##1 status_flag_register_q[abeu_pkg::STATUS_FLAG_REGISTER_I];
  endproperty
  a_ret_four: assert property (p_ret_four) else $error("interrupt return wrong");

endmodule

//--- hw/abeu_pkg.sv
// shared constants and types of the alu / branch execute unit
package abeu_pkg;

  // register byte addresses on the apb slave
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_OPD = 8'h04;
  localparam logic [7:0] ADDR_OPR = 8'h08;
  localparam logic [7:0] ADDR_IO = 8'h0c;
  localparam logic [7:0] ADDR_STATUS_FLAG_REGISTER = 8'h10;
  localparam logic [7:0] ADDR_PC = 8'h14;
  localparam logic [7:0] ADDR_EXEC = 8'h18;
  localparam logic [7:0] ADDR_RESULT = 8'h1c;

  // instruction word fields
  localparam int FLD_OP_LSB = 0;
  localparam int OP_W = 5;
  localparam int FLD_BIT_LSB = 5;
  localparam int BIT_W = 3;
  localparam int FLD_K_LSB = 8;
  localparam int K_W = 8;
  localparam int FLD_OFF_LSB = 16;
  localparam int OFF_W = 12;

  // execution status word fields
  localparam int EXS_BUSY = 0;
  localparam int EXS_TAKEN = 1;
  localparam int EXS_ILLEGAL = 2;
  localparam int EXS_CYC_LSB = 4;
  localparam int EXS_SP_LSB = 8;

  // status flag register bit positions
  localparam int STATUS_FLAG_REGISTER_C = 0;
  localparam int STATUS_FLAG_REGISTER_Z = 1;
  localparam int STATUS_FLAG_REGISTER_N = 2;
  localparam int STATUS_FLAG_REGISTER_V = 3;
  localparam int STATUS_FLAG_REGISTER_S = 4;
  localparam int STATUS_FLAG_REGISTER_H = 5;
  localparam int STATUS_FLAG_REGISTER_T = 6;
  localparam int STATUS_FLAG_REGISTER_I = 7;

  // operand bit positions for carry and overflow
  localparam int BIT_HALF = 3;
  localparam int BIT_SIGN = 7;

  // constants, cycle counts and program counter steps
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam int PC_STEP_NEXT = 1;
  localparam int PC_STEP_SKIP = 2;

  typedef enum logic [OP_W-1:0] {
    nop_op, add_carry_op, subtract_immediate_op, subtract_borrow_reg_op,
    subtract_borrow_imm_op, and_immediate_op, or_immediate_op, clear_bits_op,
    set_bits_op, test_zero_minus_op, compare_skip_equal_op, compare_immediate_op,
    skip_reg_bit_clear_op, skip_reg_bit_set_op, skip_io_bit_clear_op,
    skip_io_bit_set_op, branch_flag_set_op, branch_flag_clear_op,
    branch_signed_ge_op, branch_signed_lt_op, branch_unsigned_ge_op,
    branch_unsigned_below_op, branch_halfcarry_set_op, branch_halfcarry_clear_op,
    branch_irq_enabled_op, branch_irq_disabled_op, relative_jump_op,
    relative_call_op, subroutine_return_op, interrupt_return_op
  } abeu_op_t;

  typedef struct packed {
    logic h;
    logic v;
    logic c;
    logic [7:0] r;
  } abeu_alu_t;

endpackage

//--- tb/abeu_far_model.sv
// far side model: register file, i/o and flag bytes for the execute unit
`timescale 1ns/1ps
module abeu_far_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fresh operand word: rd, rr, i/o byte, flags
  input wire logic [31:0] word_in,
  // operand word as the unit sees it
  output logic [31:0] word_q
);
  // registered, so operands only move on an edge as a real register file would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= 32'h0000_0000;
    end else begin
      word_q <= word_in;
    end
  end
endmodule

//--- tb/alu_branch_execute_unit_bench.sv
// self-checking bench for the alu / branch execute unit
`timescale 1ns/1ps
module alu_branch_execute_unit_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv, w, seed = 32'h0000_0046, w_in = 32'h0000_0000;
  logic pready, pslverr, busy, e;
  int bad_count = 0, n_checks = 0, cyc = 0;
  always #10 pclk = ~pclk;
  abeu_core abeu_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  abeu_far_model abeu_far_model_inst (.pclk(pclk), .presetn(presetn), .word_in(w_in),
    .word_q(w));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? (x >> 1) ^ 32'h8020_0003 : x >> 1;
  endfunction
  function automatic logic [15:0] alu_exp(input logic [4:0] op, input logic [31:0] v,
      input logic [7:0] k);
    logic [7:0] d, b, s, r;
    logic [8:0] t;
    logic ci, h, ov, c;
    d = v[7:0];
    s = v[31:24];
    b = (op == 1 || op == 3) ? v[15:8] : k;
    ci = (op == 1 || op == 3 || op == 4) && s[0];
    h = s[5];
    c = s[0];
    ov = 1'b0;
    case (op)
      1: t = d + b + ci;
      5: t = {1'b0, d & k};
      6, 8: t = {1'b0, d | k};
      7: t = {1'b0, d & (abeu_pkg::MASK_ALL - k)};
      9: t = {1'b0, d};
      default: t = {1'b0, d} - b - ci;
    endcase
    r = t[7:0];
    if (op == 1) begin
      h = d[3:0] + b[3:0] + ci > 5'h0f;
      ov = d[7] == b[7] && r[7] != d[7];
      c = t[8];
    end else if (op < 5 || op == 11) begin
      h = {1'b0, d[3:0]} < b[3:0] + ci;
      ov = d[7] != b[7] && r[7] != d[7];
      c = t[8];
    end
    return {s[7:6], h, r[7] ^ ov, ov, r[7], r == 8'h00, c, r};
  endfunction
  function automatic logic cond(input logic [4:0] op, input logic [31:0] v, input logic [2:0] b);
    logic [7:0] s;
    s = v[31:24];
    case (op)
      10: return v[7:0] == v[15:8];
      12: return !v[8+b];
      13: return v[8+b];
      14: return !v[16+b];
      15: return v[16+b];
      16: return s[b];
      17: return !s[b];
      18: return !(s[2] ^ s[3]);
      19: return s[2] ^ s[3];
      20: return !s[0];
      21: return s[0];
      22: return s[5];
      23: return !s[5];
      24: return s[7];
      25: return !s[7];
      default: return 1'b1;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one idle edge first, so a release and a new setup never share a time step
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rdv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(rdv, exp);
  endtask
  // busy is counted at the port, so a wrong cycle count shows without reading status
  task automatic run(input logic [31:0] ins, input int n_exp);
    int n;
    n = 0;
    xfer(abeu_pkg::ADDR_INSTR, 1'b1, ins);
    do begin
      @(posedge pclk);
      n++;
    end while (busy === 1'b1 && n < 10);
    chk(32'(n - 1), 32'(n_exp));
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] x;
    logic [15:0] ex;
    logic [8:0] pc, np;
    logic [4:0] op;
    logic t;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int j = 0; j < 8; j++) rd(8'(4 * j), 32'h0000_0000);
    for (int i = 0; i < 179; i++) begin
      seed = lfsr(seed);
      w_in <= seed;
      seed = lfsr(seed);
      x = seed;
      pc = x[31:23];
      // compare-immediate belongs to the alu group, so the branch group runs compare-skip twice
      op = (i < 60) ? 5'(i % 10 + 1 + (i % 10 == 9)) : 5'(10 + i % 17 - (i % 17 == 1));
      // the far model registers on the first edge, so its word is settled only after the second
      repeat (2) @(posedge pclk);
      for (int j = 0; j < 4; j++) xfer(8'(4 + 4 * j), 1'b1, 32'(w[8*j+:8]));
      xfer(abeu_pkg::ADDR_PC, 1'b1, 32'(pc));
      if (i < 60) begin
        ex = alu_exp(op, w, x[15:8]);
        run({4'h0, x[27:5], op}, 1);
        rd(abeu_pkg::ADDR_OPD, 32'(op == 11 ? w[7:0] : ex[7:0]));
        rd(abeu_pkg::ADDR_STATUS_FLAG_REGISTER, 32'(ex[15:8]));
        rd(abeu_pkg::ADDR_RESULT, 32'(ex[7:0]));
        rd(abeu_pkg::ADDR_PC, 32'(pc + 9'h001));
      end else begin
        t = cond(op, w, x[7:5]);
        np = !t ? pc + 9'h001 : (op < 16 ? pc + 9'h002 : pc + x[24:16] + 9'h001);
        run({4'h0, x[27:5], op}, t ? 2 : 1);
        rd(abeu_pkg::ADDR_STATUS_FLAG_REGISTER, 32'(w[31:24]));
        rd(abeu_pkg::ADDR_PC, 32'(np));
      end
    end
    $display("alu and branch test done");
    xfer(abeu_pkg::ADDR_STATUS_FLAG_REGISTER, 1'b1, 32'h0000_0000);
    xfer(abeu_pkg::ADDR_PC, 1'b1, 32'h0000_01f0);
    run(32'h0010_001b, 3);
    rd(abeu_pkg::ADDR_PC, 32'h0000_0001);
    run(32'h0000_001c, 4);
    rd(abeu_pkg::ADDR_PC, 32'h0000_01f1);
    run(32'h0010_001b, 3);
    run(32'h0000_001d, 4);
    rd(abeu_pkg::ADDR_STATUS_FLAG_REGISTER, 32'h0000_0080);
    rd(abeu_pkg::ADDR_PC, 32'h0000_01f2);
    run(32'h0000_001e, 1);
    rd(abeu_pkg::ADDR_EXEC, 32'h0000_0014);
    rd(abeu_pkg::ADDR_PC, 32'h0000_01f3);
    $display("call and return test done");
    rd(8'h20, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    xfer(abeu_pkg::ADDR_RESULT, 1'b1, 32'h0000_00ff);
    chk(32'(e), 32'h0000_0001);
    $display("bus refusal test done");
    finish_test();
  end
endmodule
